// ==== shared/irq_agg_cfg.svh ====
// Offsets, field positions, reset values and timing figures of the interrupt aggregator.
// Assumes a 200 MHz system clock and full 32-bit host byte addresses.
`ifndef IRQ_AGG_CFG_SVH
`define IRQ_AGG_CFG_SVH

`define CFG_ADDR_SUMMARY      32'h1080_8000
`define CFG_ADDR_MASTER_EN    32'h1080_8010
`define CFG_ADDR_EXT_RAW      32'h1080_8100
`define CFG_ADDR_EXT_MASKED   32'h1080_8104
`define CFG_ADDR_EXT_EN       32'h1080_8110
`define CFG_ADDR_CARD_RAW     32'h1080_8200
`define CFG_ADDR_CARD_MASKED  32'h1080_8204
`define CFG_ADDR_CARD_EN      32'h1080_8210
`define CFG_ADDR_CARD_CLKSEL  32'h1080_8220
`define CFG_ADDR_USB_EN       32'h1080_8310
`define CFG_ADDR_FLASH_EN     32'h1080_8410

`define CFG_EXT_N             6
`define CFG_CARD_N            4
`define CFG_SYNC_N            11
`define CFG_EXT_SEN_LSB       8
`define CFG_CARD_SEN_LSB      8
`define CFG_CARD_IO_MASK      4'h5

`define CFG_SUM_CARD          0
`define CFG_SUM_SLOT1         1
`define CFG_SUM_SLOT2         2
`define CFG_SUM_DISPLAY       3
`define CFG_SUM_USB           4
`define CFG_SUM_USB_WAKE      5
`define CFG_SUM_FLASH         6
`define CFG_SUM_EXT           7

`define CFG_USB_WAKE_EN_BIT   0
`define CFG_USB_MASTER_BIT    1

`define CFG_MASTER_EN_RST     1'b1
`define CFG_WORD_ZERO         32'h0000_0000

`define CFG_CLK_PERIOD_NS     5
`define CFG_SETTLE_NS         30000
`define CFG_SETTLE_CNT_W      13

`endif

// ==== shared/irq_agg_pkg.sv ====
// Types shared by the interrupt aggregator.
// Assumes nothing beyond a SystemVerilog compiler.
package irq_agg_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0] {
        DET_SYSCLK,
        DET_SETTLE,
        DET_RTC
    } card_detect_state_t;
endpackage : irq_agg_pkg

// ==== hdl/companion_interrupt_aggregator.sv ====
// Interrupt aggregator: latches card and external requests and drives one host interrupt.
// Assumes the sub-controller requests share clk_i; card, external and RTC pins are asynchronous.
`timescale 1ns/1ps
`include "irq_agg_cfg.svh"

module companion_interrupt_aggregator #(
    parameter int unsigned SETTLE_CYCLES = (`CFG_SETTLE_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // Register access
    input  wire irq_agg_pkg::word_t    reg_addr_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire irq_agg_pkg::word_t    reg_wdata_i,
    output irq_agg_pkg::word_t         reg_rdata_o,
    // Sub-controller requests on clk_i
    input  wire logic                  slot1_status_change_req_i,
    input  wire logic                  slot2_status_change_req_i,
    input  wire logic                  display_req_i,
    input  wire logic                  usb_host_req_i,
    input  wire logic                  usb_clock_resume_req_i,
    input  wire logic                  flash_card_req_i,
    // Asynchronous pins
    input  wire logic [3:0]            bus_device_req_i,
    input  wire logic [1:0]            spare_input_req_i,
    input  wire logic [3:0]            card_req_i,
    input  wire logic                  rtc_clk_i,
    // Host interrupt
    output logic                       host_irq_o
);
    import irq_agg_pkg::*;

    logic [`CFG_SYNC_N-1:0]       pin_meta_r;
    logic [`CFG_SYNC_N-1:0]       pin_sync_r;
    logic [`CFG_SYNC_N-1:0]       pin_raw;
    logic [`CFG_EXT_N-1:0]        ext_in;
    logic [`CFG_CARD_N-1:0]       card_in;
    logic                         rtc_prev_r;
    logic                         rtc_rise;
    logic [`CFG_EXT_N-1:0]        ext_raw_r;
    logic [`CFG_EXT_N-1:0]        ext_ien_r;
    logic [`CFG_EXT_N-1:0]        ext_sen_r;
    logic [`CFG_EXT_N-1:0]        ext_set;
    logic [`CFG_CARD_N-1:0]       card_raw_r;
    logic [`CFG_CARD_N-1:0]       card_ien_r;
    logic [`CFG_CARD_N-1:0]       card_sen_r;
    logic [`CFG_CARD_N-1:0]       card_set;
    logic                         card_detect_clock_sel_r;
    logic                         master_enable_bit_r;
    logic                         usb_resume_irq_enable_r;
    logic                         usb_master_irq_enable_r;
    logic                         flash_card_irq_enable_bit_r;
    card_detect_state_t           det_state_r;
    logic [`CFG_SETTLE_CNT_W-1:0] settle_cnt_r;
    logic                         io_strobe;
    logic [7:0]                   summary;
    logic                         card_io_ring_summary;
    logic                         external_combined_req;
    word_t                        rdata_r;
    logic                         irq_r;

    function automatic logic wr_hit(input word_t addr, input word_t offs, input logic wr);
        wr_hit = wr && (addr == offs);
    endfunction : wr_hit

    // Pins are asynchronous, so each passes two flops before any logic sees it.
    assign pin_raw = {rtc_clk_i, card_req_i, spare_input_req_i, bus_device_req_i};
    genvar g;
    generate
        for (g = 0; g < `CFG_SYNC_N; g++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    pin_meta_r[g] <= 1'b0;
                    pin_sync_r[g] <= 1'b0;
                end
                else
                begin
                    pin_meta_r[g] <= pin_raw[g];
                    pin_sync_r[g] <= pin_meta_r[g];
                end
            end
        end
    endgenerate

    assign ext_in   = pin_sync_r[`CFG_EXT_N-1:0];
    assign card_in  = pin_sync_r[`CFG_EXT_N+`CFG_CARD_N-1:`CFG_EXT_N];
    assign rtc_rise = pin_sync_r[`CFG_SYNC_N-1] && !rtc_prev_r;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rtc_prev_r <= 1'b0;
        else
            rtc_prev_r <= pin_sync_r[`CFG_SYNC_N-1];
    end

    // Card I/O detection clock; the settle wait drops I/O events rather than trust a cold RTC path.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            det_state_r  <= DET_SYSCLK;
            settle_cnt_r <= '0;
        end
        else
        begin
            case (det_state_r)
                DET_SYSCLK:
                begin
                    if (card_detect_clock_sel_r)
                    begin
                        det_state_r  <= DET_SETTLE;
                        settle_cnt_r <= `CFG_SETTLE_CNT_W'(SETTLE_CYCLES - 1);
                    end
                end
                DET_SETTLE:
                begin
                    if (!card_detect_clock_sel_r)
                        det_state_r <= DET_SYSCLK;
                    else if (settle_cnt_r == '0)
                        det_state_r <= DET_RTC;
                    else
                        settle_cnt_r <= settle_cnt_r - 1'b1;
                end
                DET_RTC:
                begin
                    if (!card_detect_clock_sel_r)
                        det_state_r <= DET_SYSCLK;
                end
                default:
                    det_state_r <= DET_SYSCLK;
            endcase
        end
    end

    always_comb
    begin
        case (det_state_r)
            DET_SYSCLK: io_strobe = 1'b1;
            DET_RTC:    io_strobe = rtc_rise;
            default:    io_strobe = 1'b0;
        endcase
    end

    assign ext_set  = ext_in & ext_sen_r;
    assign card_set = card_in & card_sen_r & (io_strobe ? 4'hf : ~`CFG_CARD_IO_MASK);

    // Latched status; a new request in the clearing cycle survives the clear.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ext_raw_r  <= '0;
            card_raw_r <= '0;
        end
        else
        begin
            ext_raw_r <= (ext_raw_r & ~(wr_hit(reg_addr_i, `CFG_ADDR_EXT_RAW, reg_wr_i)
                          ? reg_wdata_i[`CFG_EXT_N-1:0] : '0)) | ext_set;
            card_raw_r <= (card_raw_r & ~(wr_hit(reg_addr_i, `CFG_ADDR_CARD_RAW, reg_wr_i)
                           ? reg_wdata_i[`CFG_CARD_N-1:0] : '0)) | card_set;
        end
    end

    // Software-written controls.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            master_enable_bit_r         <= `CFG_MASTER_EN_RST;
            ext_ien_r                   <= '0;
            ext_sen_r                   <= '0;
            card_ien_r                  <= '0;
            card_sen_r                  <= '0;
            card_detect_clock_sel_r     <= 1'b0;
            usb_resume_irq_enable_r     <= 1'b0;
            usb_master_irq_enable_r     <= 1'b0;
            flash_card_irq_enable_bit_r <= 1'b0;
        end
        else
        begin
            if (wr_hit(reg_addr_i, `CFG_ADDR_MASTER_EN, reg_wr_i))
                master_enable_bit_r <= reg_wdata_i[0];
            if (wr_hit(reg_addr_i, `CFG_ADDR_EXT_EN, reg_wr_i))
            begin
                ext_ien_r <= reg_wdata_i[`CFG_EXT_N-1:0];
                ext_sen_r <= reg_wdata_i[`CFG_EXT_SEN_LSB+`CFG_EXT_N-1:`CFG_EXT_SEN_LSB];
            end
            if (wr_hit(reg_addr_i, `CFG_ADDR_CARD_EN, reg_wr_i))
            begin
                card_ien_r <= reg_wdata_i[`CFG_CARD_N-1:0];
                card_sen_r <= reg_wdata_i[`CFG_CARD_SEN_LSB+`CFG_CARD_N-1:`CFG_CARD_SEN_LSB];
            end
            if (wr_hit(reg_addr_i, `CFG_ADDR_CARD_CLKSEL, reg_wr_i))
                card_detect_clock_sel_r <= reg_wdata_i[0];
            if (wr_hit(reg_addr_i, `CFG_ADDR_USB_EN, reg_wr_i))
            begin
                usb_resume_irq_enable_r <= reg_wdata_i[`CFG_USB_WAKE_EN_BIT];
                usb_master_irq_enable_r <= reg_wdata_i[`CFG_USB_MASTER_BIT];
            end
            if (wr_hit(reg_addr_i, `CFG_ADDR_FLASH_EN, reg_wr_i))
                flash_card_irq_enable_bit_r <= reg_wdata_i[0];
        end
    end

    assign card_io_ring_summary  = |(card_raw_r & card_ien_r);
    assign external_combined_req = |(ext_raw_r & ext_ien_r);

    always_comb
    begin
        summary                   = 8'h00;
        summary[`CFG_SUM_CARD]     = card_io_ring_summary;
        summary[`CFG_SUM_SLOT1]    = slot1_status_change_req_i;
        summary[`CFG_SUM_SLOT2]    = slot2_status_change_req_i;
        summary[`CFG_SUM_DISPLAY]  = display_req_i;
        summary[`CFG_SUM_USB]      = usb_host_req_i && usb_master_irq_enable_r;
        summary[`CFG_SUM_USB_WAKE] = usb_clock_resume_req_i && usb_master_irq_enable_r
                                     && usb_resume_irq_enable_r;
        summary[`CFG_SUM_FLASH]    = flash_card_req_i && flash_card_irq_enable_bit_r;
        summary[`CFG_SUM_EXT]      = external_combined_req;
    end

    // Reads have no side effects; an unmapped address reads as zero.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_r <= `CFG_WORD_ZERO;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `CFG_ADDR_SUMMARY:     rdata_r <= {24'h0, summary};
                `CFG_ADDR_MASTER_EN:   rdata_r <= {31'h0, master_enable_bit_r};
                `CFG_ADDR_EXT_RAW:     rdata_r <= {26'h0, ext_raw_r};
                `CFG_ADDR_EXT_MASKED:  rdata_r <= {26'h0, ext_raw_r & ext_ien_r};
                `CFG_ADDR_EXT_EN:      rdata_r <= {18'h0, ext_sen_r, 2'h0, ext_ien_r};
                `CFG_ADDR_CARD_RAW:    rdata_r <= {28'h0, card_raw_r};
                `CFG_ADDR_CARD_MASKED: rdata_r <= {28'h0, card_raw_r & card_ien_r};
                `CFG_ADDR_CARD_EN:     rdata_r <= {20'h0, card_sen_r, 4'h0, card_ien_r};
                `CFG_ADDR_CARD_CLKSEL: rdata_r <= {31'h0, card_detect_clock_sel_r};
                `CFG_ADDR_USB_EN:      rdata_r <= {30'h0, usb_master_irq_enable_r, usb_resume_irq_enable_r};
                `CFG_ADDR_FLASH_EN:    rdata_r <= {31'h0, flash_card_irq_enable_bit_r};
                default:               rdata_r <= `CFG_WORD_ZERO;
            endcase
        end
    end

    // Host software is expected to drop the master enable while handling, so that
    // re-enabling produces a fresh edge for anything still pending.
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_r <= 1'b0;
        else
            irq_r <= (|summary) && master_enable_bit_r;
    end

    assign reg_rdata_o = rdata_r;
    assign host_irq_o  = irq_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_rd_summary;
        reg_rd_i && (reg_addr_i == `CFG_ADDR_SUMMARY);
    endsequence

    sequence s_rd_card_masked;
        reg_rd_i && (reg_addr_i == `CFG_ADDR_CARD_MASKED);
    endsequence

    AST_MASTER_BLOCKS: assert property (
        !master_enable_bit_r |=> !host_irq_o)
        else $error("Host interrupt raised while master enable was clear.");

    AST_IRQ_RAISE: assert property (
        (master_enable_bit_r && (|summary)) |=> host_irq_o)
        else $error("Host interrupt missing with a pending source and master enable.");

    AST_EXT_LATCH: assert property (
        (|ext_set) |=> ((ext_raw_r & $past(ext_set)) == $past(ext_set)))
        else $error("Enabled external request was not latched.");

    AST_EXT_INPUT_BLOCK: assert property (
        ((ext_raw_r & ~ext_sen_r) == '0) ##1 ($stable(ext_sen_r) && !reg_wr_i)[*2]
        |-> ((ext_raw_r & ~ext_sen_r) == '0))
        else $error("External bit latched while its input enable was clear.");

    AST_CARD_W1C: assert property (
        (wr_hit(reg_addr_i, `CFG_ADDR_CARD_RAW, reg_wr_i) && (card_set == '0))
        |=> (({28'h0, card_raw_r} & $past(reg_wdata_i)) == '0))
        else $error("Card status bit survived a write of one without a new request.");

    AST_CARD_MASKED_READ: assert property (
        s_rd_card_masked |=> (reg_rdata_o == {28'h0, $past(card_raw_r) & $past(card_ien_r)}))
        else $error("Masked card status read differs from status AND enable.");

    AST_USB_GATED: assert property (
        (s_rd_summary and !usb_master_irq_enable_r) |=> (reg_rdata_o[5:4] == 2'b00))
        else $error("USB summary bits visible with USB master enable clear.");

    AST_FLASH_HIDDEN: assert property (
        (s_rd_summary and !flash_card_irq_enable_bit_r) |=> !reg_rdata_o[`CFG_SUM_FLASH])
        else $error("Flash card request visible while its enable was clear.");

    AST_SETTLE_NO_IO: assert property (
        (det_state_r == DET_SYSCLK && card_detect_clock_sel_r) |=>
        (det_state_r == DET_SETTLE && !io_strobe)[*2])
        else $error("Card I/O detection ran without the RTC settle wait.");

endmodule : companion_interrupt_aggregator

// ==== verification/host_bus_model.sv ====
// Host-side model: register strobes toward the aggregator and the interrupt service sequence.
// Assumes the aggregator takes strobes on the rising edge of clk_i and registers read data on that same edge.
`timescale 1ns/1ps
`include "irq_agg_cfg.svh"
module host_bus_model
(
    // Clock
    input  wire logic               clk_i,
    // Register access
    output irq_agg_pkg::word_t      reg_addr_o,
    output logic                    reg_wr_o,
    output logic                    reg_rd_o,
    output irq_agg_pkg::word_t      reg_wdata_o,
    input  wire irq_agg_pkg::word_t reg_rdata_i
);
    import irq_agg_pkg::*;
    initial
    begin
        reg_addr_o  = 32'h0;
        reg_wdata_o = 32'h0;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // Released address and data lines show the inverse of the last value so a stale address never passes for a live one.
    task automatic access(input word_t a, input word_t d, input logic w, output word_t q);
        @(negedge clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = w;
        reg_rd_o    = ~w;
        @(negedge clk_i);
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
        q           = reg_rdata_i;
    endtask : access
    // Masking first means a source still pending raises the line again once service ends.
    task automatic service(output word_t s);
        word_t q;
        access(`CFG_ADDR_MASTER_EN, 32'h0, 1'b1, q);
        access(`CFG_ADDR_SUMMARY, 32'h0, 1'b0, s);
        access(`CFG_ADDR_MASTER_EN, 32'h1, 1'b1, q);
    endtask : service
endmodule : host_bus_model

// ==== verification/companion_interrupt_aggregator_bench.sv ====
// Self-checking bench for the interrupt aggregator, driving inputs on the falling clock edge.
// Assumes the host model in its own file and a short settle count for the RTC detection path.
`timescale 1ns/1ps
`include "irq_agg_cfg.svh"
module companion_interrupt_aggregator_bench;
    import irq_agg_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    word_t       reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    word_t       reg_wdata;
    word_t       reg_rdata;
    logic [5:0]  src = 6'h0;
    logic [3:0]  bus_dev = 4'h0;
    logic [1:0]  spare = 2'h0;
    logic [3:0]  card = 4'h0;
    logic        rtc = 1'b0;
    logic        irq;
    int          err_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'hfe11;
    word_t       r, q, e, c;
    word_t       addr_tab[12] = '{`CFG_ADDR_SUMMARY, `CFG_ADDR_MASTER_EN, `CFG_ADDR_EXT_RAW, `CFG_ADDR_EXT_MASKED,
        `CFG_ADDR_EXT_EN, `CFG_ADDR_CARD_RAW, `CFG_ADDR_CARD_MASKED, `CFG_ADDR_CARD_EN, `CFG_ADDR_CARD_CLKSEL,
        `CFG_ADDR_USB_EN, `CFG_ADDR_FLASH_EN, 32'h1080_8ffc};
    word_t       rst_tab[12] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    word_t       msk_tab[12] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h3f3f, 32'h0, 32'h0, 32'h0f0f, 32'h1, 32'h3,
        32'h1, 32'h0};
    always #2.5 clk = ~clk;
    companion_interrupt_aggregator #(.SETTLE_CYCLES(8)) DUT (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .slot1_status_change_req_i(src[0]), .slot2_status_change_req_i(src[1]), .display_req_i(src[2]),
        .usb_host_req_i(src[3]), .usb_clock_resume_req_i(src[4]), .flash_card_req_i(src[5]),
        .bus_device_req_i(bus_dev), .spare_input_req_i(spare), .card_req_i(card), .rtc_clk_i(rtc),
        .host_irq_o(irq));
    host_bus_model HOST (.clk_i(clk), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Bits of r: 5:0 sources, 8 wake enable, 9 USB master, 10 flash enable.
    function automatic word_t exp_summary(input word_t v);
        return {24'h0, 1'b0, v[5] & v[10], v[4] & v[8] & v[9], v[3] & v[9], v[2:0], 1'b0};
    endfunction : exp_summary
    task automatic finish_test();
        $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input word_t got, input word_t exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task automatic wr(input word_t a, input word_t d);
        word_t t;
        HOST.access(a, d, 1'b1, t);
    endtask : wr
    task automatic rd_chk(input word_t a, input word_t exp);
        word_t t;
        HOST.access(a, 32'h0, 1'b0, t);
        chk(t, exp);
    endtask : rd_chk
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    initial
    begin
        wait_n(2);
        rst_b = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            rd_chk(addr_tab[i], rst_tab[i]);
            wr(addr_tab[i], 32'hffff_ffff);
            rd_chk(addr_tab[i], msk_tab[i]);
            wr(addr_tab[i], rst_tab[i]);
        end
        $display("test register map done");
        for (int k = 0; k < 5; k++)
        begin
            r = (k == 0) ? 32'h3f3f : xs();
            q = (k == 0) ? 32'h3f : xs();
            wr(`CFG_ADDR_EXT_EN, {18'h0, r[13:8], 2'h0, r[5:0]});
            {spare, bus_dev} = q[5:0];
            wait_n(4);
            {spare, bus_dev} = 6'h0;
            wait_n(2);
            e = {26'h0, q[5:0] & r[13:8]};
            rd_chk(`CFG_ADDR_EXT_RAW, e);
            rd_chk(`CFG_ADDR_EXT_MASKED, e & {26'h0, r[5:0]});
            rd_chk(`CFG_ADDR_SUMMARY, {24'h0, |(e[5:0] & r[5:0]), 7'h0});
            chk({31'h0, irq}, {31'h0, |(e[5:0] & r[5:0])});
            c = xs() & 32'h3f;
            wr(`CFG_ADDR_EXT_RAW, c);
            rd_chk(`CFG_ADDR_EXT_RAW, e & ~c);
            wr(`CFG_ADDR_EXT_RAW, 32'h3f);
        end
        wr(`CFG_ADDR_EXT_EN, 32'h3f);
        bus_dev = 4'hf;
        wait_n(5);
        bus_dev = 4'h0;
        rd_chk(`CFG_ADDR_EXT_RAW, 32'h0);
        $display("test external inputs done");
        for (int k = 0; k < 5; k++)
        begin
            r = (k == 0) ? 32'h0f0f : xs();
            q = (k == 0) ? 32'hf : xs();
            wr(`CFG_ADDR_CARD_EN, {20'h0, r[11:8], 4'h0, r[3:0]});
            card = q[3:0];
            wait_n(4);
            card = 4'h0;
            wait_n(2);
            e = {28'h0, q[3:0] & r[11:8]};
            rd_chk(`CFG_ADDR_CARD_RAW, e);
            rd_chk(`CFG_ADDR_CARD_MASKED, e & {28'h0, r[3:0]});
            rd_chk(`CFG_ADDR_SUMMARY, {31'h0, |(e[3:0] & r[3:0])});
            wr(`CFG_ADDR_CARD_RAW, 32'hf);
            rd_chk(`CFG_ADDR_CARD_RAW, 32'h0);
        end
        $display("test card inputs done");
        for (int k = 0; k < 10; k++)
        begin
            r = (k == 0) ? 32'hfff : xs();
            src = r[5:0];
            wr(`CFG_ADDR_USB_EN, {30'h0, r[9:8]});
            wr(`CFG_ADDR_FLASH_EN, {31'h0, r[10]});
            wr(`CFG_ADDR_MASTER_EN, {31'h0, r[11]});
            wait_n(1);
            e = exp_summary(r);
            chk({31'h0, irq}, {31'h0, (|e) & r[11]});
            rd_chk(`CFG_ADDR_SUMMARY, e);
            HOST.service(q);
            chk(q, e);
            wait_n(1);
            chk({31'h0, irq}, {31'h0, |e});
        end
        src = 6'h0;
        $display("test summary and master enable done");
        wr(`CFG_ADDR_MASTER_EN, 32'h0);
        wr(`CFG_ADDR_USB_EN, 32'h3);
        rst_b = 1'b0;
        wait_n(2);
        rst_b = 1'b1;
        rd_chk(`CFG_ADDR_MASTER_EN, 32'h1);
        rd_chk(`CFG_ADDR_USB_EN, 32'h0);
        $display("test mid-run reset done");
        wr(`CFG_ADDR_CARD_EN, 32'h0505);
        wr(`CFG_ADDR_CARD_CLKSEL, 32'h1);
        card = 4'h5;
        wait_n(2);
        card = 4'h0;
        wait_n(12);
        rd_chk(`CFG_ADDR_CARD_RAW, 32'h0);
        card = 4'h5;
        wait_n(8);
        rd_chk(`CFG_ADDR_CARD_RAW, 32'h0);
        rtc = 1'b1;
        wait_n(6);
        rd_chk(`CFG_ADDR_CARD_RAW, 32'h5);
        card = 4'h0;
        rtc = 1'b0;
        wr(`CFG_ADDR_CARD_CLKSEL, 32'h0);
        wr(`CFG_ADDR_CARD_RAW, 32'hf);
        card = 4'h1;
        wait_n(5);
        rd_chk(`CFG_ADDR_CARD_RAW, 32'h1);
        $display("test card detect clock done");
        finish_test();
    end
endmodule : companion_interrupt_aggregator_bench
